// File: logic/pld_cfg_regs.sv
// configuration and status register bank with array input gating
//
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
module pld_cfg_regs
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic power_on_reset_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	input wire logic [7:0] oe_port_a,
	input wire logic [7:0] oe_port_b,
	input wire logic [7:0] oe_port_c,
	input wire logic [7:0] oe_port_f,
	input wire logic [7:0] input_cells_a,
	input wire logic [7:0] input_cells_b,
	input wire logic [7:0] input_cells_c,
	input wire logic [7:0] main_sector_flags,
	input wire logic [3:0] boot_sector_flags,
	input wire logic security_lock_set,
	input wire logic [3:0] map_user_config,
	input wire logic split_bus_mode,
	input pld_cfg_pkg::pin_in_t pins,
	output logic [7:0] slew_mode_c,
	output logic [7:0] slew_mode_f,
	output logic [7:0] output_cells_a,
	output logic [7:0] output_cells_b,
	output logic test_port_on,
	output logic [7:0] page_select_bits,
	output logic auto_power_down,
	output logic array_fast_mode_off,
	output pld_cfg_pkg::array_in_t array_in,
	output pld_cfg_pkg::access_t access
);

	// -----------------------------------------------------------------------
	// storage
	// -----------------------------------------------------------------------
	logic [7:0] slew_c_ff;
	logic [7:0] slew_f_ff;
	logic [7:0] cell_a_ff;
	logic [7:0] cell_b_ff;
	logic [7:0] mask_a_ff;
	logic [7:0] mask_b_ff;
	logic [7:0] test_port_ff;
	logic [7:0] page_ff;
	logic [7:0] clock_gate_ff;
	logic [7:0] input_gate_ff;
	logic [7:0] space_map_ff;
	logic map_load_ff;
	logic [7:0] rdata_ff;
	logic [7:0] nxt_rdata;
	pld_cfg_pkg::pin_in_t pin_meta_ff;
	pld_cfg_pkg::pin_in_t pin_sync_ff;
	logic clock_seen_ff;
	logic [2:0] sync_fill_ff;
	pld_cfg_pkg::array_in_t array_ff;
	pld_cfg_pkg::access_t access_ff;
	logic [7:0] nxt_address;

	function automatic logic wr_at(input logic [7:0] ofs);
		wr_at = reg_write && (reg_addr == ofs);
	endfunction

	function automatic logic [7:0] masked_load(input logic [7:0] old_v,
		input logic [7:0] new_v, input logic [7:0] mask_v);
		masked_load = (old_v & mask_v) | (new_v & ~mask_v);
	endfunction

	// -----------------------------------------------------------------------
	// port and cell registers
	// -----------------------------------------------------------------------
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			slew_c_ff <= pld_cfg_pkg::RESET_REG;
			slew_f_ff <= pld_cfg_pkg::RESET_REG;
		end
		else
		begin
			if (wr_at(pld_cfg_pkg::OFS_SLEW_C))
				slew_c_ff <= reg_wdata;
			if (wr_at(pld_cfg_pkg::OFS_SLEW_F))
				slew_f_ff <= reg_wdata;
		end
	end

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			mask_a_ff <= pld_cfg_pkg::RESET_REG;
			mask_b_ff <= pld_cfg_pkg::RESET_REG;
		end
		else
		begin
			if (wr_at(pld_cfg_pkg::OFS_MASK_A))
				mask_a_ff <= reg_wdata;
			if (wr_at(pld_cfg_pkg::OFS_MASK_B))
				mask_b_ff <= reg_wdata;
		end
	end

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			cell_a_ff <= pld_cfg_pkg::RESET_REG;
			cell_b_ff <= pld_cfg_pkg::RESET_REG;
		end
		else
		begin
			if (wr_at(pld_cfg_pkg::OFS_CELL_A))
				cell_a_ff <= masked_load(cell_a_ff, reg_wdata, mask_a_ff);
			if (wr_at(pld_cfg_pkg::OFS_CELL_B))
				cell_b_ff <= masked_load(cell_b_ff, reg_wdata, mask_b_ff);
		end
	end

	// -----------------------------------------------------------------------
	// control registers
	// -----------------------------------------------------------------------
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			test_port_ff <= pld_cfg_pkg::RESET_REG;
			page_ff <= pld_cfg_pkg::RESET_REG;
			input_gate_ff <= pld_cfg_pkg::RESET_REG;
		end
		else
		begin
			if (wr_at(pld_cfg_pkg::OFS_TEST_PORT))
				test_port_ff <= reg_wdata & pld_cfg_pkg::MASK_TEST_PORT;
			if (wr_at(pld_cfg_pkg::OFS_PAGE))
				page_ff <= reg_wdata;
			if (wr_at(pld_cfg_pkg::OFS_INPUT_GATE))
				input_gate_ff <= reg_wdata & pld_cfg_pkg::MASK_INPUT_GATE;
		end
	end

	// only the power-on reset clears it; the reset pin does not
	always_ff @(posedge clock or negedge power_on_reset_n)
	begin
		if (!power_on_reset_n)
			clock_gate_ff <= pld_cfg_pkg::RESET_REG;
		else if (reset_n && wr_at(pld_cfg_pkg::OFS_CLOCK_GATE))
			clock_gate_ff <= reg_wdata & pld_cfg_pkg::MASK_CLOCK_GATE;
	end

	// reset clears the map; the first edge after release loads the config
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			space_map_ff <= pld_cfg_pkg::RESET_REG;
			map_load_ff <= 1'b1;
		end
		else if (map_load_ff)
		begin
			space_map_ff[4:1] <= map_user_config;
			map_load_ff <= 1'b0;
		end
		else if (wr_at(pld_cfg_pkg::OFS_SPACE_MAP))
			space_map_ff <= reg_wdata & pld_cfg_pkg::MASK_SPACE_MAP;
	end

	// -----------------------------------------------------------------------
	// read path
	// -----------------------------------------------------------------------
	always_comb
	begin
		unique case (reg_addr)
			pld_cfg_pkg::OFS_INPUT_CELL_A: nxt_rdata = input_cells_a;
			pld_cfg_pkg::OFS_INPUT_CELL_B: nxt_rdata = input_cells_b;
			pld_cfg_pkg::OFS_INPUT_CELL_C: nxt_rdata = input_cells_c;
			pld_cfg_pkg::OFS_OE_VIEW_A: nxt_rdata = oe_port_a;
			pld_cfg_pkg::OFS_OE_VIEW_B: nxt_rdata = oe_port_b;
			pld_cfg_pkg::OFS_OE_VIEW_C: nxt_rdata = oe_port_c;
			pld_cfg_pkg::OFS_OE_VIEW_F: nxt_rdata = oe_port_f;
			pld_cfg_pkg::OFS_SLEW_C: nxt_rdata = slew_c_ff;
			pld_cfg_pkg::OFS_SLEW_F: nxt_rdata = slew_f_ff;
			pld_cfg_pkg::OFS_CELL_A: nxt_rdata = cell_a_ff;
			pld_cfg_pkg::OFS_CELL_B: nxt_rdata = cell_b_ff;
			pld_cfg_pkg::OFS_MASK_A: nxt_rdata = mask_a_ff;
			pld_cfg_pkg::OFS_MASK_B: nxt_rdata = mask_b_ff;
			pld_cfg_pkg::OFS_CLOCK_GATE: nxt_rdata = clock_gate_ff;
			pld_cfg_pkg::OFS_INPUT_GATE: nxt_rdata = input_gate_ff;
			pld_cfg_pkg::OFS_MAIN_PROTECT: nxt_rdata = main_sector_flags;
			pld_cfg_pkg::OFS_BOOT_PROTECT:
				nxt_rdata = {security_lock_set, 3'h0, boot_sector_flags};
			pld_cfg_pkg::OFS_TEST_PORT: nxt_rdata = test_port_ff;
			pld_cfg_pkg::OFS_PAGE: nxt_rdata = page_ff;
			pld_cfg_pkg::OFS_SPACE_MAP: nxt_rdata = space_map_ff;
			pld_cfg_pkg::OFS_SIZE_INFO: nxt_rdata = {pld_cfg_pkg::SRAM_SIZE_CODE,
				pld_cfg_pkg::PRIMARY_SIZE_CODE};
			default: nxt_rdata = 8'h00;
		endcase
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			rdata_ff <= 8'h00;
		else if (reg_read)
			rdata_ff <= nxt_rdata;
		else
			rdata_ff <= 8'h00;
	end

	// -----------------------------------------------------------------------
	// pin synchroniser
	// -----------------------------------------------------------------------
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pin_meta_ff <= '0;
			pin_sync_ff <= '0;
			clock_seen_ff <= 1'b0;
			sync_fill_ff <= 3'h0;
		end
		else
		begin
			pin_meta_ff <= pins;
			pin_sync_ff <= pin_meta_ff;
			clock_seen_ff <= pin_sync_ff.external_clock_input;
			// wakeup waits until the chain holds real pin samples
			sync_fill_ff <= {sync_fill_ff[1:0], 1'b1};
		end
	end

	// -----------------------------------------------------------------------
	// array input gating
	// -----------------------------------------------------------------------
	always_comb
	begin
		if (split_bus_mode)
			nxt_address = {pin_sync_ff.muxed_bus_upper_lines,
				pin_sync_ff.port_f_low_pins};
		else
			nxt_address = pin_sync_ff.low_address;
		if (input_gate_ff[pld_cfg_pkg::BIT_LOW_ADDRESS])
			nxt_address = 8'h00;
	end

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			array_ff <= '0;
		else
		begin
			array_ff.array_address <= nxt_address;
			array_ff.control_pins <= pin_sync_ff.control_pins &
				~input_gate_ff[pld_cfg_pkg::BIT_CONTROL_ZERO +: 3];
			array_ff.latch_enable <= pin_sync_ff.latch_enable &
				~input_gate_ff[pld_cfg_pkg::BIT_LATCH_ENABLE];
			array_ff.high_byte_write_strobe <=
				pin_sync_ff.high_byte_write_strobe &
				~input_gate_ff[pld_cfg_pkg::BIT_HIGH_WRITE];
			array_ff.array_clock <= pin_sync_ff.external_clock_input &
				~clock_gate_ff[pld_cfg_pkg::BIT_ARRAY_CLOCK];
			array_ff.cell_clock <= pin_sync_ff.external_clock_input &
				~clock_gate_ff[pld_cfg_pkg::BIT_CELL_CLOCK];
			array_ff.array_wakeup <=
				(pin_sync_ff.external_clock_input != clock_seen_ff) &&
				sync_fill_ff[2] &&
				!clock_gate_ff[pld_cfg_pkg::BIT_ARRAY_CLOCK] &&
				clock_gate_ff[pld_cfg_pkg::BIT_FAST_MODE_OFF];
		end
	end

	// -----------------------------------------------------------------------
	// memory space access
	// -----------------------------------------------------------------------
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			access_ff <= '0;
		else
		begin
			access_ff.fetch_reaches_sram <= split_bus_mode && space_map_ff[0];
			access_ff.fetch_reaches_secondary <=
				split_bus_mode && space_map_ff[1];
			access_ff.fetch_reaches_primary <= split_bus_mode && space_map_ff[2];
			access_ff.read_reaches_secondary <=
				split_bus_mode && space_map_ff[3];
			access_ff.read_reaches_primary <= split_bus_mode && space_map_ff[4];
			access_ff.port_f_peripheral <=
				space_map_ff[pld_cfg_pkg::BIT_PERIPHERAL];
		end
	end

	assign reg_rdata = rdata_ff;
	assign slew_mode_c = slew_c_ff;
	assign slew_mode_f = slew_f_ff;
	assign output_cells_a = cell_a_ff;
	assign output_cells_b = cell_b_ff;
	assign test_port_on = test_port_ff[0];
	assign page_select_bits = page_ff;
	assign auto_power_down =
		clock_gate_ff[pld_cfg_pkg::BIT_AUTO_POWER_DOWN];
	assign array_fast_mode_off =
		clock_gate_ff[pld_cfg_pkg::BIT_FAST_MODE_OFF];
	assign array_in = array_ff;
	assign access = access_ff;

	// -----------------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!reset_n);

	sequence s_cell_a_write;
		reg_write && reg_addr == pld_cfg_pkg::OFS_CELL_A;
	endsequence

	sequence s_map_release;
		map_load_ff ##1 !map_load_ff;
	endsequence

	AST_SLEW_WRITE: assert property (
		reg_write && reg_addr == pld_cfg_pkg::OFS_SLEW_C
		|=> slew_mode_c == $past(reg_wdata))
		else $error("slew select c not loaded");
	AST_OE_READ: assert property (
		reg_read && reg_addr == pld_cfg_pkg::OFS_OE_VIEW_F
		|=> reg_rdata == $past(oe_port_f))
		else $error("output enable view wrong");
	AST_IMC_READ: assert property (
		reg_read && reg_addr == pld_cfg_pkg::OFS_INPUT_CELL_C
		|=> reg_rdata == $past(input_cells_c))
		else $error("input cell read wrong");
	AST_CELL_MASK: assert property (
		s_cell_a_write |=> output_cells_a == (($past(output_cells_a) &
		$past(mask_a_ff)) | ($past(reg_wdata) & ~$past(mask_a_ff))))
		else $error("masked cell load wrong");
	AST_CELL_READBACK: assert property (
		s_cell_a_write ##[1:2]
		(reg_read && reg_addr == pld_cfg_pkg::OFS_CELL_A)
		|=> reg_rdata == $past(output_cells_a))
		else $error("cell readback wrong");
	AST_BOOT_READ: assert property (
		reg_read && reg_addr == pld_cfg_pkg::OFS_BOOT_PROTECT
		|=> reg_rdata[7] == $past(security_lock_set) && reg_rdata[6:4] == 3'h0
		&& reg_rdata[3:0] == $past(boot_sector_flags))
		else $error("boot protect read wrong");
	AST_UNUSED_ZERO: assert property (
		reg_read && reg_addr == pld_cfg_pkg::OFS_TEST_PORT
		|=> reg_rdata[7:1] == 7'h00)
		else $error("unused test port bits not zero");
	AST_MAP_LOAD: assert property (
		s_map_release |-> space_map_ff[4:1] == $past(map_user_config)
		&& space_map_ff[0] == 1'b0 && space_map_ff[7] == 1'b0)
		else $error("map config not loaded at reset release");
	AST_MAP_GATE: assert property (
		##1 !split_bus_mode |=> !access.fetch_reaches_primary
		&& !access.read_reaches_primary)
		else $error("access granted outside split mode");
	AST_ADDR_BLOCK: assert property (
		input_gate_ff[pld_cfg_pkg::BIT_LOW_ADDRESS]
		|=> array_in.array_address == 8'h00)
		else $error("low address not blocked");
	AST_SIZE_READ: assert property (
		reg_read && reg_addr == pld_cfg_pkg::OFS_SIZE_INFO
		|=> reg_rdata == 8'h35)
		else $error("size register wrong");
	AST_PAGE_RESET: assert property (
		map_load_ff |-> page_select_bits == 8'h00)
		else $error("page not zero after reset");

endmodule

// File: logic/pld_cfg_pkg.sv
// constants, field layout and carrier types of the configuration register bank
// ---------------------------------------------------------------------------
// How it works
// - slew select bit one picks slew mode
// - output enable view reads driver enables
// - input cell registers read live cell state
// - output cell write loads, read returns flops
// - mask bit one blocks host load
// - main sector protect reads eight sector flags
// - boot protect low nibble reports sector protection
// - boot protect top bit reports security lock
// - test port enable bit zero switches port
// - page register drives decoder, resets zero
// - clock gate register clears only at power-up
// - clock gate bit one enables auto power-down
// - clock gate bit three turns fast mode off
// - bit four disconnects array clock, else wakes if bit three set
// - bit five disconnects macrocell clock
// - input gate bit zero blocks low address
// - bits two to six block control inputs
// - split mode takes address from pins
// - map reset loads config, clears bits zero, seven
// - map bits grant fetch and read access in split mode
// - map bit seven enables port f peripheral
// - size register encodes flash and sram size
// ---------------------------------------------------------------------------
package pld_cfg_pkg;

	// -----------------------------------------------------------------------
	// register offsets
	// -----------------------------------------------------------------------
	localparam logic [7:0] OFS_INPUT_CELL_A = 8'h0A;
	localparam logic [7:0] OFS_INPUT_CELL_B = 8'h0B;
	localparam logic [7:0] OFS_INPUT_CELL_C = 8'h1A;
	localparam logic [7:0] OFS_OE_VIEW_A = 8'h0C;
	localparam logic [7:0] OFS_OE_VIEW_B = 8'h0D;
	localparam logic [7:0] OFS_OE_VIEW_C = 8'h1C;
	localparam logic [7:0] OFS_OE_VIEW_F = 8'h4C;
	localparam logic [7:0] OFS_SLEW_C = 8'h18;
	localparam logic [7:0] OFS_SLEW_F = 8'h48;
	localparam logic [7:0] OFS_CELL_A = 8'h20;
	localparam logic [7:0] OFS_CELL_B = 8'h21;
	localparam logic [7:0] OFS_MASK_A = 8'h22;
	localparam logic [7:0] OFS_MASK_B = 8'h23;
	localparam logic [7:0] OFS_CLOCK_GATE = 8'hB0;
	localparam logic [7:0] OFS_INPUT_GATE = 8'hB4;
	localparam logic [7:0] OFS_MAIN_PROTECT = 8'hC0;
	localparam logic [7:0] OFS_BOOT_PROTECT = 8'hC2;
	localparam logic [7:0] OFS_TEST_PORT = 8'hC7;
	localparam logic [7:0] OFS_PAGE = 8'hE0;
	localparam logic [7:0] OFS_SPACE_MAP = 8'hE2;
	localparam logic [7:0] OFS_SIZE_INFO = 8'hF0;

	// -----------------------------------------------------------------------
	// writable bit masks, field positions, reset values
	// -----------------------------------------------------------------------
	localparam logic [7:0] MASK_CLOCK_GATE = 8'h3A;
	localparam logic [7:0] MASK_INPUT_GATE = 8'h7D;
	localparam logic [7:0] MASK_SPACE_MAP = 8'h9F;
	localparam logic [7:0] MASK_TEST_PORT = 8'h01;
	localparam int BIT_AUTO_POWER_DOWN = 1;
	localparam int BIT_FAST_MODE_OFF = 3;
	localparam int BIT_ARRAY_CLOCK = 4;
	localparam int BIT_CELL_CLOCK = 5;
	localparam int BIT_LOW_ADDRESS = 0;
	localparam int BIT_CONTROL_ZERO = 2;
	localparam int BIT_LATCH_ENABLE = 5;
	localparam int BIT_HIGH_WRITE = 6;
	localparam int BIT_PERIPHERAL = 7;
	localparam logic [7:0] RESET_REG = 8'h00;
	localparam logic [3:0] PRIMARY_SIZE_CODE = 4'h5;
	localparam logic [3:0] SRAM_SIZE_CODE = 4'h3;

	// -----------------------------------------------------------------------
	// carriers
	// -----------------------------------------------------------------------
	typedef struct packed {
		logic [2:0] control_pins;
		logic latch_enable;
		logic high_byte_write_strobe;
		logic external_clock_input;
		logic [3:0] port_f_low_pins;
		logic [3:0] muxed_bus_upper_lines;
		logic [7:0] low_address;
	} pin_in_t;

	typedef struct packed {
		logic [2:0] control_pins;
		logic latch_enable;
		logic high_byte_write_strobe;
		logic array_clock;
		logic cell_clock;
		logic array_wakeup;
		logic [7:0] array_address;
	} array_in_t;

	typedef struct packed {
		logic fetch_reaches_sram;
		logic fetch_reaches_secondary;
		logic fetch_reaches_primary;
		logic read_reaches_secondary;
		logic read_reaches_primary;
		logic port_f_peripheral;
	} access_t;

endpackage

// File: verif/pld_host_model.sv
// host bus master model driving the register port of the bank
`timescale 1ns/1ps
module pld_host_model
(
	input wire logic clock,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_write,
	output logic reg_read,
	input wire logic [7:0] reg_rdata
);
	initial
	begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_write = 1'b0;
		reg_read = 1'b0;
	end

	// released write data shows the inverse, never a stale copy
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
		reg_wdata <= ~d;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
endmodule

// File: verif/pld_io_power_config_regs_tb.sv
// self-checking bench for the configuration register bank
`timescale 1ns/1ps
module pld_io_power_config_regs_tb;
	logic clock, reset_n, power_on_reset_n, reg_write, reg_read;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic [7:0] oe_port_a, oe_port_b, oe_port_c, oe_port_f;
	logic [7:0] input_cells_a, input_cells_b, input_cells_c;
	logic [7:0] main_sector_flags, slew_mode_c, slew_mode_f;
	logic [3:0] boot_sector_flags, map_user_config;
	logic security_lock_set, split_bus_mode, test_port_on;
	logic auto_power_down, array_fast_mode_off;
	logic [7:0] output_cells_a, output_cells_b, page_select_bits;
	pld_cfg_pkg::pin_in_t pins;
	pld_cfg_pkg::array_in_t array_in;
	pld_cfg_pkg::access_t access;
	int errors, n_tests, cycles;
	logic [7:0] v, w, m, ig, cg;
	logic [7:0] ofs [4];
	logic [7:0] msk [4];

	pld_host_model u_host (.clock(clock), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata));

	pld_cfg_regs u_dut (.clock(clock), .reset_n(reset_n),
		.power_on_reset_n(power_on_reset_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .oe_port_a(oe_port_a),
		.oe_port_b(oe_port_b), .oe_port_c(oe_port_c),
		.oe_port_f(oe_port_f), .input_cells_a(input_cells_a),
		.input_cells_b(input_cells_b), .input_cells_c(input_cells_c),
		.main_sector_flags(main_sector_flags),
		.boot_sector_flags(boot_sector_flags),
		.security_lock_set(security_lock_set),
		.map_user_config(map_user_config),
		.split_bus_mode(split_bus_mode), .pins(pins),
		.slew_mode_c(slew_mode_c), .slew_mode_f(slew_mode_f),
		.output_cells_a(output_cells_a), .output_cells_b(output_cells_b),
		.test_port_on(test_port_on), .page_select_bits(page_select_bits),
		.auto_power_down(auto_power_down),
		.array_fast_mode_off(array_fast_mode_off),
		.array_in(array_in), .access(access));

	// -----------------------------------------------------------------------
	// clock, timeout, checking
	// -----------------------------------------------------------------------
	initial
	begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 6000)
		begin
			errors++;
			end_of_test();
		end
	end

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen,
				exp);
		end
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		u_host.rd(a, d);
		chk({8'h00, d}, {8'h00, exp});
	endtask

	task automatic pulse_reset(input logic por);
		@(posedge clock);
		reset_n <= 1'b0;
		power_on_reset_n <= ~por;
		repeat (5) @(posedge clock);
		reset_n <= 1'b1;
		power_on_reset_n <= 1'b1;
		@(posedge clock);
	endtask

	function automatic pld_cfg_pkg::array_in_t exp_array(
		input pld_cfg_pkg::pin_in_t p, input logic [7:0] g,
		input logic [7:0] c, input logic sp);
		pld_cfg_pkg::array_in_t e;
		e.control_pins = p.control_pins & ~g[4:2];
		e.latch_enable = p.latch_enable & ~g[5];
		e.high_byte_write_strobe = p.high_byte_write_strobe & ~g[6];
		e.array_clock = p.external_clock_input & ~c[4];
		e.cell_clock = p.external_clock_input & ~c[5];
		e.array_wakeup = 1'b0;
		e.array_address = g[0] ? 8'h00 : (sp ?
			{p.muxed_bus_upper_lines, p.port_f_low_pins} : p.low_address);
		return e;
	endfunction

	// -----------------------------------------------------------------------
	// main sequence
	// -----------------------------------------------------------------------
	initial
	begin
		void'($urandom(7));
		{errors, n_tests, cycles} = '0;
		{oe_port_a, oe_port_b, oe_port_c, oe_port_f} = '0;
		{input_cells_a, input_cells_b, input_cells_c} = '0;
		{main_sector_flags, boot_sector_flags, security_lock_set} = '0;
		split_bus_mode = 1'b0;
		pins = '0;
		map_user_config = 4'($urandom);
		reset_n = 1'b0;
		power_on_reset_n = 1'b0;
		repeat (5) @(posedge clock);
		reset_n <= 1'b1;
		power_on_reset_n <= 1'b1;
		@(posedge clock);
		rdchk(pld_cfg_pkg::OFS_PAGE, 8'h00);
		rdchk(pld_cfg_pkg::OFS_CLOCK_GATE, 8'h00);
		rdchk(pld_cfg_pkg::OFS_SIZE_INFO, 8'h35);
		rdchk(pld_cfg_pkg::OFS_SPACE_MAP, {3'h0, map_user_config, 1'b0});
		rdchk(8'h55, 8'h00);
		$display("test reset values done");

		repeat (3)
		begin
			@(posedge clock);
			{oe_port_a, oe_port_b, oe_port_c, oe_port_f} <= 32'($urandom);
			{input_cells_a, input_cells_b, input_cells_c} <= 24'($urandom);
			main_sector_flags <= 8'($urandom);
			{boot_sector_flags, security_lock_set} <= 5'($urandom);
			u_host.wr(pld_cfg_pkg::OFS_MAIN_PROTECT, 8'hFF);
			rdchk(pld_cfg_pkg::OFS_OE_VIEW_A, oe_port_a);
			rdchk(pld_cfg_pkg::OFS_OE_VIEW_B, oe_port_b);
			rdchk(pld_cfg_pkg::OFS_OE_VIEW_C, oe_port_c);
			rdchk(pld_cfg_pkg::OFS_OE_VIEW_F, oe_port_f);
			rdchk(pld_cfg_pkg::OFS_INPUT_CELL_A, input_cells_a);
			rdchk(pld_cfg_pkg::OFS_INPUT_CELL_B, input_cells_b);
			rdchk(pld_cfg_pkg::OFS_INPUT_CELL_C, input_cells_c);
			rdchk(pld_cfg_pkg::OFS_MAIN_PROTECT, main_sector_flags);
			u_host.wr(pld_cfg_pkg::OFS_BOOT_PROTECT, 8'h70);
			rdchk(pld_cfg_pkg::OFS_BOOT_PROTECT,
				{security_lock_set, 3'h0, boot_sector_flags});
		end
		$display("test read-only views done");

		v = 8'($urandom);
		u_host.wr(pld_cfg_pkg::OFS_SLEW_C, v);
		u_host.wr(pld_cfg_pkg::OFS_SLEW_F, ~v);
		rdchk(pld_cfg_pkg::OFS_SLEW_C, v);
		chk({slew_mode_c, slew_mode_f}, {v, ~v});
		$display("test slew select done");

		for (int g = 0; g < 2; g++)
		begin
			v = 8'($urandom);
			w = 8'($urandom);
			m = 8'($urandom);
			u_host.wr(pld_cfg_pkg::OFS_MASK_A + 8'(g), 8'h00);
			u_host.wr(pld_cfg_pkg::OFS_CELL_A + 8'(g), v);
			u_host.wr(pld_cfg_pkg::OFS_MASK_A + 8'(g), m);
			u_host.wr(pld_cfg_pkg::OFS_CELL_A + 8'(g), w);
			rdchk(pld_cfg_pkg::OFS_CELL_A + 8'(g), (v & m) | (w & ~m));
			chk(g ? output_cells_b : output_cells_a, (v & m) | (w & ~m));
		end
		$display("test output cells done");

		ofs = '{pld_cfg_pkg::OFS_TEST_PORT, pld_cfg_pkg::OFS_CLOCK_GATE,
			pld_cfg_pkg::OFS_INPUT_GATE, pld_cfg_pkg::OFS_SPACE_MAP};
		msk = '{8'h01, 8'h3A, 8'h7D, 8'h9F};
		for (int i = 0; i < 4; i++)
		begin
			u_host.wr(ofs[i], 8'hFF);
			rdchk(ofs[i], msk[i]);
		end
		chk({test_port_on, auto_power_down, array_fast_mode_off}, 3'h7);
		v = 8'($urandom);
		u_host.wr(pld_cfg_pkg::OFS_PAGE, v);
		#1;
		chk(page_select_bits, v);
		for (int i = 0; i < 4; i++)
			u_host.wr(ofs[i], 8'h00);
		#1;
		chk({test_port_on, auto_power_down, array_fast_mode_off}, 3'h0);
		for (int i = 0; i < 6; i++)
		begin
			v = 8'($urandom) & 8'h9F;
			@(posedge clock);
			split_bus_mode <= i[0];
			u_host.wr(pld_cfg_pkg::OFS_SPACE_MAP, v);
			// access flops follow the map one edge later
			@(posedge clock);
			#1;
			chk(access, {{5{split_bus_mode}} & {v[0], v[1], v[2], v[3], v[4]},
				v[7]});
		end
		$display("test writable registers done");

		for (int i = 0; i < 10; i++)
		begin
			ig = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
			cg = (i == 0) ? 8'h00 : 8'($urandom);
			u_host.wr(pld_cfg_pkg::OFS_INPUT_GATE, ig);
			u_host.wr(pld_cfg_pkg::OFS_CLOCK_GATE, cg);
			@(posedge clock);
			pins <= 22'($urandom);
			split_bus_mode <= 1'($urandom);
			repeat (6) @(posedge clock);
			#1;
			chk(array_in, exp_array(pins, ig, cg, split_bus_mode));
		end
		cg = 8'h08;
		for (int i = 0; i < 2; i++)
		begin
			u_host.wr(pld_cfg_pkg::OFS_CLOCK_GATE, cg);
			@(posedge clock);
			pins.external_clock_input <= ~pins.external_clock_input;
			w = 8'h00;
			repeat (8)
			begin
				@(posedge clock);
				#1;
				w = w + 8'(array_in.array_wakeup);
			end
			chk(w, {7'h00, ~cg[4]});
			cg = 8'h18;
		end
		$display("test array gating done");

		u_host.wr(pld_cfg_pkg::OFS_CLOCK_GATE, 8'h3A);
		u_host.wr(pld_cfg_pkg::OFS_PAGE, 8'h5A);
		pulse_reset(1'b0);
		rdchk(pld_cfg_pkg::OFS_CLOCK_GATE, 8'h3A);
		rdchk(pld_cfg_pkg::OFS_PAGE, 8'h00);
		pulse_reset(1'b1);
		rdchk(pld_cfg_pkg::OFS_CLOCK_GATE, 8'h00);
		$display("test reset kinds done");
		end_of_test();
	end
endmodule
